//--- rtl/motion_scaler_pkg.sv
// Register map, field layout and reset values for the motion current scaler
package motion_scaler_pkg;
    // ------------------------------------------------------------------
    // Bus geometry: byte address is four times the register index
    // ------------------------------------------------------------------
    localparam int ADDR_W = 9;
    localparam int IDX_W = 7;
    localparam logic [IDX_W-1:0] IDX_CONFIG = 7'h05;
    localparam logic [IDX_W-1:0] IDX_SCALES = 7'h06;
    localparam logic [IDX_W-1:0] IDX_STANDBY = 7'h15;
    localparam logic [IDX_W-1:0] IDX_COAST = 7'h16;
    localparam logic [IDX_W-1:0] IDX_THRESH = 7'h17;
    localparam logic [IDX_W-1:0] IDX_UP = 7'h18;
    localparam logic [IDX_W-1:0] IDX_HOLD = 7'h19;
    localparam logic [IDX_W-1:0] IDX_DOWN = 7'h1A;
    localparam logic [IDX_W-1:0] IDX_BOOST = 7'h1B;
    localparam logic [IDX_W-1:0] IDX_LEVEL = 7'h7C;
    localparam logic [IDX_W-1:0] IDX_STATUS = 7'h7D;

    // ------------------------------------------------------------------
    // current_scaling_config bits
    // ------------------------------------------------------------------
    localparam int CFG_HOLD_EN = 0;
    localparam int CFG_DRV_EN = 1;
    localparam int CFG_DRV2_EN = 2;
    localparam int CFG_BST_START = 3;
    localparam int CFG_BST_ACC = 4;
    localparam int CFG_BST_DEC = 5;
    localparam int CFG_COAST_EN = 6;

    // ------------------------------------------------------------------
    // scale_value_set fields (low bit of each 8-bit field)
    // ------------------------------------------------------------------
    localparam int SCL_BOOST_LSB = 0;
    localparam int SCL_DRV1_LSB = 8;
    localparam int SCL_DRV2_LSB = 16;
    localparam int SCL_HOLD_LSB = 24;

    // ------------------------------------------------------------------
    // Status register fields
    // ------------------------------------------------------------------
    localparam int ST_PHASE_LSB = 0;
    localparam int ST_HOLD = 2;
    localparam int ST_COAST = 3;
    localparam int ST_BOOST = 4;
    localparam int ST_TARGET_LSB = 8;

    // ------------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------------
    localparam logic [31:0] CONFIG_RST = 32'h0000_0000;
    localparam logic [31:0] SCALES_RST = 32'hFFFF_FFFF;
    localparam logic [31:0] DELAY_RST = 32'h0000_0000;
    localparam logic [31:0] THRESH_RST = 32'h0000_0000;
    localparam logic [7:0] FULL_SCALE = 8'hFF;
    localparam logic [1:0] PH_CONST = 2'h0;
    localparam logic [1:0] PH_ACC = 2'h1;
    localparam logic [1:0] PH_DEC = 2'h2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : motion_scaler_pkg

//--- rtl/motion_current_scaler.sv
// Motion current scaler: target selection, smooth level ramp, AXI4-Lite registers
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module motion_current_scaler (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic signed [31:0] ramp_velocity_now_i,
    input wire logic signed [8:0] coil_a_i,
    input wire logic signed [8:0] coil_b_i,
    output logic signed [8:0] coil_a_scaled_o,
    output logic signed [8:0] coil_b_scaled_o,
    output logic [7:0] actual_scale_level_o,
    output logic [1:0] ramp_phase_o,
    output logic hold_active_o,
    output logic coast_active_o,
    input wire logic [motion_scaler_pkg::ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [motion_scaler_pkg::ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i
);
    import motion_scaler_pkg::*;

    // ------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------
    logic [31:0] cfg_ff, nxt_cfg, scl_ff, nxt_scl, stby_ff, nxt_stby, coast_ff, nxt_coast;
    logic [31:0] thr_ff, nxt_thr, up_ff, nxt_up, hold_ff, nxt_hold, down_ff, nxt_down;
    logic [31:0] bst_ff, nxt_bst, wdata_ff, nxt_wdata, rdata_ff, nxt_rdata;
    logic [3:0] wstrb_ff, nxt_wstrb;
    logic [ADDR_W-1:0] waddr_ff, nxt_waddr;
    logic awready_ff, nxt_awready, wready_ff, nxt_wready, bvalid_ff, nxt_bvalid;
    logic arready_ff, nxt_arready, rvalid_ff, nxt_rvalid;
    logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
    logic [31:0] status_word;
    logic [7:0] target_ff, nxt_target, level_ff, nxt_level;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] st);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            res[i*8 +: 8] = st[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
        end
        return res;
    endfunction : merge

    always_comb begin
        {nxt_cfg, nxt_scl, nxt_stby, nxt_coast, nxt_thr, nxt_up, nxt_hold, nxt_down, nxt_bst} =
            {cfg_ff, scl_ff, stby_ff, coast_ff, thr_ff, up_ff, hold_ff, down_ff, bst_ff};
        {nxt_waddr, nxt_wdata, nxt_wstrb, nxt_rdata} = {waddr_ff, wdata_ff, wstrb_ff, rdata_ff};
        {nxt_awready, nxt_wready, nxt_bvalid, nxt_arready, nxt_rvalid} =
            {awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff};
        {nxt_bresp, nxt_rresp} = {bresp_ff, rresp_ff};
        // Address and data are latched separately so either may come first
        if (s_axi_awvalid_i && awready_ff) begin
            nxt_awready = 1'b0;
            nxt_waddr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && wready_ff) begin
            nxt_wready = 1'b0;
            nxt_wdata = s_axi_wdata_i;
            nxt_wstrb = s_axi_wstrb_i;
        end
        if (!awready_ff && !wready_ff && !bvalid_ff) begin
            nxt_bvalid = 1'b1;
            nxt_bresp = RESP_OKAY;
            case (waddr_ff[ADDR_W-1:2])
                IDX_CONFIG: nxt_cfg = merge(cfg_ff, wdata_ff, wstrb_ff);
                IDX_SCALES: nxt_scl = merge(scl_ff, wdata_ff, wstrb_ff);
                IDX_STANDBY: nxt_stby = merge(stby_ff, wdata_ff, wstrb_ff);
                IDX_COAST: nxt_coast = merge(coast_ff, wdata_ff, wstrb_ff);
                IDX_THRESH: nxt_thr = merge(thr_ff, wdata_ff, wstrb_ff);
                IDX_UP: nxt_up = merge(up_ff, wdata_ff, wstrb_ff);
                IDX_HOLD: nxt_hold = merge(hold_ff, wdata_ff, wstrb_ff);
                IDX_DOWN: nxt_down = merge(down_ff, wdata_ff, wstrb_ff);
                IDX_BOOST: nxt_bst = merge(bst_ff, wdata_ff, wstrb_ff);
                IDX_LEVEL, IDX_STATUS: nxt_bresp = RESP_OKAY;
                default: nxt_bresp = RESP_SLVERR;
            endcase
        end
        if (bvalid_ff && s_axi_bready_i) begin
            nxt_bvalid = 1'b0;
            nxt_awready = 1'b1;
            nxt_wready = 1'b1;
        end
        if (s_axi_arvalid_i && arready_ff) begin
            nxt_arready = 1'b0;
            nxt_rvalid = 1'b1;
            nxt_rresp = RESP_OKAY;
            case (s_axi_araddr_i[ADDR_W-1:2])
                IDX_CONFIG: nxt_rdata = cfg_ff;
                IDX_SCALES: nxt_rdata = scl_ff;
                IDX_STANDBY: nxt_rdata = stby_ff;
                IDX_COAST: nxt_rdata = coast_ff;
                IDX_THRESH: nxt_rdata = thr_ff;
                IDX_UP: nxt_rdata = up_ff;
                IDX_HOLD: nxt_rdata = hold_ff;
                IDX_DOWN: nxt_rdata = down_ff;
                IDX_BOOST: nxt_rdata = bst_ff;
                IDX_LEVEL: nxt_rdata = {24'h00_0000, level_ff};
                IDX_STATUS: nxt_rdata = status_word;
                default: begin
                    nxt_rdata = 32'h0000_0000;
                    nxt_rresp = RESP_SLVERR;
                end
            endcase
        end
        if (rvalid_ff && s_axi_rready_i) begin
            nxt_rvalid = 1'b0;
            nxt_arready = 1'b1;
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            {cfg_ff, scl_ff, thr_ff} <= {CONFIG_RST, SCALES_RST, THRESH_RST};
            {stby_ff, coast_ff, up_ff, hold_ff, down_ff, bst_ff} <= {6{DELAY_RST}};
            {waddr_ff, wdata_ff, wstrb_ff, rdata_ff} <= '0;
            {awready_ff, wready_ff, arready_ff} <= 3'h7;
            {bvalid_ff, rvalid_ff} <= 2'h0;
            {bresp_ff, rresp_ff} <= {RESP_OKAY, RESP_OKAY};
        end else begin
            {cfg_ff, scl_ff, thr_ff} <= {nxt_cfg, nxt_scl, nxt_thr};
            {stby_ff, coast_ff, up_ff} <= {nxt_stby, nxt_coast, nxt_up};
            {hold_ff, down_ff, bst_ff} <= {nxt_hold, nxt_down, nxt_bst};
            {waddr_ff, wdata_ff, wstrb_ff, rdata_ff} <= {nxt_waddr, nxt_wdata, nxt_wstrb, nxt_rdata};
            {awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff} <=
                {nxt_awready, nxt_wready, nxt_bvalid, nxt_arready, nxt_rvalid};
            {bresp_ff, rresp_ff} <= {nxt_bresp, nxt_rresp};
        end
    end

    // ------------------------------------------------------------------
    // Ramp watch, timers and target selection
    // ------------------------------------------------------------------
    logic signed [31:0] prev_v_ff;
    logic [31:0] abs_v, prev_abs, boost_cnt_ff, nxt_boost_cnt, stby_cnt_ff, nxt_stby_cnt;
    logic [31:0] coast_cnt_ff, nxt_coast_cnt;
    logic [1:0] phase_ff, nxt_phase;
    logic hold_on_ff, nxt_hold_on, coast_on_ff, nxt_coast_on;
    logic moving, start_evt, flip, boost_any, fast;

    assign abs_v = ramp_velocity_now_i[31] ? 32'(-ramp_velocity_now_i) : ramp_velocity_now_i;
    assign prev_abs = prev_v_ff[31] ? 32'(-prev_v_ff) : prev_v_ff;
    assign moving = ramp_velocity_now_i != 32'h0000_0000;
    assign start_evt = moving && prev_v_ff == 32'h0000_0000;
    assign flip = moving && prev_v_ff != 32'h0000_0000 && prev_v_ff[31] != ramp_velocity_now_i[31];
    assign fast = cfg_ff[CFG_DRV2_EN] && abs_v > thr_ff;
    assign boost_any = boost_cnt_ff != 32'h0000_0000
        || (cfg_ff[CFG_BST_ACC] && nxt_phase == PH_ACC)
        || (cfg_ff[CFG_BST_DEC] && nxt_phase == PH_DEC);

    always_comb begin
        nxt_phase = PH_CONST;
        if (start_evt || flip) begin
            nxt_phase = PH_ACC;
        end else if (moving && abs_v > prev_abs) begin
            nxt_phase = PH_ACC;
        end else if (moving && abs_v < prev_abs) begin
            nxt_phase = PH_DEC;
        end
        nxt_boost_cnt = 32'h0000_0000;
        if (start_evt && cfg_ff[CFG_BST_START]) begin
            nxt_boost_cnt = bst_ff;
        end else if (moving && boost_cnt_ff != 32'h0000_0000) begin
            nxt_boost_cnt = boost_cnt_ff - 32'h0000_0001;
        end
        nxt_stby_cnt = stby_cnt_ff;
        nxt_coast_cnt = coast_cnt_ff;
        nxt_hold_on = hold_on_ff;
        nxt_coast_on = coast_on_ff;
        if (moving) begin
            nxt_stby_cnt = stby_ff;
            nxt_coast_cnt = coast_ff;
            nxt_hold_on = 1'b0;
            nxt_coast_on = 1'b0;
        end else if (!hold_on_ff) begin
            if (stby_cnt_ff == 32'h0000_0000) begin
                nxt_hold_on = 1'b1;
            end else begin
                nxt_stby_cnt = stby_cnt_ff - 32'h0000_0001;
            end
        end else if (coast_cnt_ff != 32'h0000_0000) begin
            nxt_coast_cnt = coast_cnt_ff - 32'h0000_0001;
        end else begin
            nxt_coast_on = cfg_ff[CFG_COAST_EN];
        end
        // Before standby expires the last motion target is kept
        nxt_target = target_ff;
        if (moving) begin
            if (boost_any) begin
                nxt_target = scl_ff[SCL_BOOST_LSB +: 8];
            end else if (cfg_ff[CFG_DRV_EN]) begin
                nxt_target = fast ? scl_ff[SCL_DRV2_LSB +: 8] : scl_ff[SCL_DRV1_LSB +: 8];
            end else begin
                nxt_target = FULL_SCALE;
            end
        end else if (hold_on_ff) begin
            nxt_target = cfg_ff[CFG_HOLD_EN] ? scl_ff[SCL_HOLD_LSB +: 8] : FULL_SCALE;
        end
    end

    // ------------------------------------------------------------------
    // Level ramp toward the target
    // ------------------------------------------------------------------
    logic [31:0] step_cnt_ff, nxt_step_cnt, dly;
    logic hold_phase;
    logic signed [18:0] prod_a, prod_b;
    logic signed [8:0] out_a_ff, out_b_ff;

    assign hold_phase = hold_on_ff && cfg_ff[CFG_HOLD_EN];
    assign dly = target_ff > level_ff ? up_ff : (hold_phase ? hold_ff : down_ff);

    always_comb begin
        nxt_level = level_ff;
        nxt_step_cnt = 32'h0000_0000;
        if (level_ff == target_ff) begin
            nxt_step_cnt = 32'h0000_0000;
        end else if (dly == 32'h0000_0000) begin
            nxt_level = target_ff;
        end else if (step_cnt_ff >= dly - 32'h0000_0001) begin
            // Comparing with >= lets a shorter new delay take effect at once
            nxt_level = target_ff > level_ff ? level_ff + 8'h01 : level_ff - 8'h01;
        end else begin
            nxt_step_cnt = step_cnt_ff + 32'h0000_0001;
        end
    end

    assign prod_a = coil_a_i * $signed({1'b0, {1'b0, level_ff} + 9'h001});
    assign prod_b = coil_b_i * $signed({1'b0, {1'b0, level_ff} + 9'h001});

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            {prev_v_ff, boost_cnt_ff, stby_cnt_ff, coast_cnt_ff, step_cnt_ff} <= '0;
            {phase_ff, hold_on_ff, coast_on_ff} <= {PH_CONST, 2'h0};
            {target_ff, level_ff} <= {FULL_SCALE, FULL_SCALE};
            {out_a_ff, out_b_ff} <= '0;
        end else begin
            prev_v_ff <= ramp_velocity_now_i;
            phase_ff <= nxt_phase;
            boost_cnt_ff <= nxt_boost_cnt;
            stby_cnt_ff <= nxt_stby_cnt;
            coast_cnt_ff <= nxt_coast_cnt;
            hold_on_ff <= nxt_hold_on;
            coast_on_ff <= nxt_coast_on;
            target_ff <= nxt_target;
            level_ff <= nxt_level;
            step_cnt_ff <= nxt_step_cnt;
            out_a_ff <= coast_on_ff ? 9'sh000 : prod_a[16:8];
            out_b_ff <= coast_on_ff ? 9'sh000 : prod_b[16:8];
        end
    end

    assign status_word = {16'h0000, target_ff, 3'h0, boost_cnt_ff != 32'h0000_0000,
                          coast_on_ff, hold_on_ff, phase_ff};
    assign coil_a_scaled_o = out_a_ff;
    assign coil_b_scaled_o = out_b_ff;
    assign actual_scale_level_o = level_ff;
    assign ramp_phase_o = phase_ff;
    assign hold_active_o = hold_on_ff;
    assign coast_active_o = coast_on_ff;
    assign s_axi_awready_o = awready_ff;
    assign s_axi_wready_o = wready_ff;
    assign s_axi_bvalid_o = bvalid_ff;
    assign s_axi_bresp_o = bresp_ff;
    assign s_axi_arready_o = arready_ff;
    assign s_axi_rvalid_o = rvalid_ff;
    assign s_axi_rresp_o = rresp_ff;
    assign s_axi_rdata_o = rdata_ff;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);

    sequence stop_expired;
        !moving && !hold_on_ff && stby_cnt_ff == 32'h0000_0000;
    endsequence
    sequence level_read;
        s_axi_arvalid_i && arready_ff && s_axi_araddr_i[ADDR_W-1:2] == IDX_LEVEL;
    endsequence

    chk_drive_select: assert property (moving && !boost_any && cfg_ff[CFG_DRV_EN]
        |=> target_ff == ($past(fast) ? $past(scl_ff[23:16]) : $past(scl_ff[15:8])))
        else $error("drive target not chosen by speed");
    chk_boost_load: assert property (start_evt && cfg_ff[CFG_BST_START]
        |=> boost_cnt_ff == $past(bst_ff))
        else $error("boost timer not loaded");
    chk_acc_phase: assert property (moving && !start_evt && !flip && abs_v > prev_abs
        |=> phase_ff == PH_ACC)
        else $error("acceleration phase missing");
    chk_dec_phase: assert property (moving && !flip && abs_v < prev_abs
        |=> phase_ff == PH_DEC)
        else $error("deceleration phase missing");
    chk_hold_step: assert property (hold_phase && target_ff < level_ff
        && hold_ff != 32'h0000_0000 && step_cnt_ff >= hold_ff - 32'h0000_0001
        |=> level_ff == $past(level_ff) - 8'h01)
        else $error("hold step wrong");
    chk_hold_jump: assert property (hold_phase && hold_ff == 32'h0000_0000
        && target_ff < level_ff |=> level_ff == $past(target_ff))
        else $error("hold load not immediate");
    chk_up_step: assert property (target_ff > level_ff && up_ff != 32'h0000_0000
        && step_cnt_ff < up_ff - 32'h0000_0001 |=> level_ff == $past(level_ff))
        else $error("level rose early");
    chk_up_jump: assert property (target_ff > level_ff && up_ff == 32'h0000_0000
        |=> level_ff == $past(target_ff))
        else $error("up jump missing");
    chk_down_jump: assert property (!hold_phase && target_ff < level_ff
        && down_ff == 32'h0000_0000 |=> level_ff == $past(target_ff))
        else $error("down jump missing");
    chk_zero_cross: assert property (flip |=> phase_ff == PH_ACC ##0
        (!cfg_ff[CFG_BST_ACC] || target_ff == scl_ff[7:0]))
        else $error("zero crossing not seen as acceleration");
    chk_no_overshoot: assert property ($changed(level_ff) && !$past(hold_phase)
        |-> (level_ff > $past(level_ff)) == ($past(target_ff) > $past(level_ff)))
        else $error("level moved away from target");
    chk_scale_mult: assert property (!coast_on_ff
        |=> coil_a_scaled_o == $past(prod_a[16:8]))
        else $error("coil scaling wrong");
    chk_level_read: assert property (level_read
        |=> s_axi_rvalid_o && s_axi_rdata_o == {24'h00_0000, $past(level_ff)})
        else $error("level readback wrong");
    chk_standby_hold: assert property (stop_expired |=> hold_on_ff)
        else $error("hold not entered after standby");
endmodule : motion_current_scaler
`default_nettype wire

//--- dv/motion_current_scaler_tb.sv
// Self-checking bench for the motion current scaler
`timescale 1ns/1ns
`default_nettype none
module motion_current_scaler_tb;
    import motion_scaler_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, arv = 1'b0;
    logic signed [31:0] vel = 32'sh0;
    logic [ADDR_W-1:0] awa = '0, ara = '0;
    logic [31:0] wd = 32'h0, rdo;
    logic awr, wrdy, bv, arr, rv, hold, cst;
    logic [1:0] br, rr, ph;
    logic [7:0] lvl;
    logic signed [8:0] ca, cb, cbi = 9'sh19C;
    int error_cnt = 0, compares = 0;
    motion_current_scaler motion_current_scaler_i (.mclk_i(clk), .reset_n_i(rst_n),
        .ramp_velocity_now_i(vel), .coil_a_i(9'sh064), .coil_b_i(cbi),
        .coil_a_scaled_o(ca), .coil_b_scaled_o(cb), .actual_scale_level_o(lvl),
        .ramp_phase_o(ph), .hold_active_o(hold), .coast_active_o(cst),
        .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
        .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy),
        .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(1'b1),
        .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
        .s_axi_rdata_o(rdo), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(1'b1));
    // ------------------------------------------------------------------
    // Bus cycles and checks; ready sampled as it stood before each edge
    // ------------------------------------------------------------------
    task automatic summarize;
        if (error_cnt == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : summarize
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [6:0] idx, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        awa <= {idx, 2'h0}; wd <= d; awv <= 1'b1; wv <= 1'b1;
        do begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
            n++;
        end while (!bv && n < 100);
        r = br;
        if (n >= 100) begin error_cnt++; summarize(); end
    endtask : wr
    task automatic rd(input logic [6:0] idx, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        ara <= {idx, 2'h0}; arv <= 1'b1;
        do begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
            n++;
        end while (!rv && n < 100);
        d = rdo; r = rr;
        if (n >= 100) begin error_cnt++; summarize(); end
    endtask : rd
    task automatic wait_lvl(input logic [7:0] v, output int n);
        n = 0;
        while (lvl !== v && n < 1000) begin @(posedge clk); n++; end
        if (n >= 1000) begin error_cnt++; summarize(); end
    endtask : wait_lvl
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_regs;
        logic [31:0] d; logic [1:0] r;
        rd(IDX_SCALES, d, r); chk("scales_rst", SCALES_RST, d);
        rd(IDX_LEVEL, d, r); chk("level_rst", 32'h0000_00FF, d);
        rd(7'h7F, d, r); chk("rresp_unmapped", RESP_SLVERR, r);
        wr(7'h7F, 32'h1, r); chk("bresp_unmapped", RESP_SLVERR, r);
    endtask : t_regs
    task automatic t_drive;
        logic [31:0] d; logic [1:0] r; int n;
        wr(IDX_SCALES, 32'h1080_40C0, r); wr(IDX_THRESH, 32'd100, r); wr(IDX_CONFIG, 32'h6, r);
        vel <= 32'sd50; wait_lvl(8'h40, n);
        repeat (3) @(posedge clk);
        chk("coil_scaled", 32'h19, {23'h0, ca});
        chk("coil_b_scaled", 32'h1E6, {23'h0, cb});
        vel <= 32'sd100; repeat (6) @(posedge clk);
        chk("level_at_limit", 32'h40, {24'h0, lvl});
        vel <= 32'sd101; wait_lvl(8'h80, n);
        rd(IDX_LEVEL, d, r); chk("level_read", 32'h80, d);
    endtask : t_drive
    task automatic t_ramp;
        logic [1:0] r; int n;
        wr(IDX_DOWN, 32'd3, r); vel <= 32'sd50; wait_lvl(8'h40, n);
        chk("down_cycles", 32'h1, {31'h0, n >= 189 && n <= 195});
        wr(IDX_UP, 32'd2, r); vel <= 32'sd150; wait_lvl(8'h80, n);
        chk("up_cycles", 32'h1, {31'h0, n >= 125 && n <= 131});
    endtask : t_ramp
    task automatic t_boost;
        logic [1:0] r;
        wr(IDX_DOWN, 32'd0, r); wr(IDX_UP, 32'd0, r); wr(IDX_CONFIG, 32'h36, r);
        repeat (8) begin @(posedge clk); vel <= vel + 32'sd1; end
        chk("phase_acc", PH_ACC, ph);
        chk("level_acc", 32'hC0, {24'h0, lvl});
        repeat (8) begin @(posedge clk); vel <= vel - 32'sd1; end
        chk("phase_dec", PH_DEC, ph);
        chk("level_dec", 32'hC0, {24'h0, lvl});
        repeat (6) @(posedge clk);
        chk("phase_const", PH_CONST, ph);
        chk("level_const", 32'h80, {24'h0, lvl});
    endtask : t_boost
    task automatic t_hold;
        logic [1:0] r; int n;
        wr(IDX_STANDBY, 32'd5, r); wr(IDX_CONFIG, 32'h47, r);
        vel <= 32'sd0; wait_lvl(8'h10, n);
        chk("standby_cycles", 32'h1, {31'h0, n >= 5 && n <= 10});
        chk("hold_flag", 32'h1, {31'h0, hold});
        vel <= 32'sd150; wait_lvl(8'h80, n);
        wr(IDX_HOLD, 32'd4, r); vel <= 32'sd0; wait_lvl(8'h10, n);
        chk("hold_cycles", 32'h1, {31'h0, n >= 448 && n <= 460});
        chk("coast_flag", 32'h1, {31'h0, cst});
        chk("coast_zero", 32'h0, {23'h0, ca});
    endtask : t_hold
    task automatic t_start;
        logic [31:0] d; logic [1:0] r; int n;
        wr(IDX_BOOST, 32'd20, r); wr(IDX_CONFIG, 32'h1B, r);
        chk("bresp_ok", RESP_OKAY, r);
        vel <= 32'sd50; repeat (5) @(posedge clk);
        chk("level_boost", 32'hC0, {24'h0, lvl});
        rd(IDX_STATUS, d, r); chk("status_boost", 32'h0000_C010, d);
        wait_lvl(8'h40, n);
        chk("boost_cycles", 32'h1, {31'h0, n >= 15 && n <= 19});
        vel <= -32'sd50; repeat (2) @(posedge clk);
        chk("phase_cross", PH_ACC, ph);
        @(posedge clk); chk("level_cross", 32'hC0, {24'h0, lvl});
    endtask : t_start
    initial begin
        forever #20 clk = ~clk;
    end
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_regs(); t_drive(); t_ramp(); t_boost(); t_hold(); t_start();
        summarize();
    end
endmodule : motion_current_scaler_tb
`default_nettype wire
